// ===== rtl/dbs_link_if.sv
`timescale 1ns/1ps
interface dbs_link_if #(
	parameter int DATA_W = dbs_pkg::DATA_W_DEF,
	parameter int ADDR_W = dbs_pkg::pair_addr_w(DATA_W),
	parameter int MASK_W = DATA_W / dbs_pkg::lane_w(DATA_W)
);
	// Input clock pair, made by the controller
	logic              k_clk;
	logic              k_n_clk;
	// Command
	logic              load_strobe_n;
	logic              rw;
	logic [ADDR_W-1:0] addr;
	// Per-beat write lane masks, active low
	logic [MASK_W-1:0] write_mask_n;
	// Shared data lanes: each end drives with an enable
	logic [DATA_W-1:0] ctl_dq_o;
	logic              ctl_dq_oe;
	logic [DATA_W-1:0] dev_dq_o;
	logic              dev_dq_oe;
	wire  [DATA_W-1:0] dq;
	// Read return
	logic              echo_clock;
	logic              echo_clock_n;
	logic              read_valid_flag;

	// Wire level from the two enables; released lanes read as zero
	assign dq = ctl_dq_oe ? ctl_dq_o : (dev_dq_oe ? dev_dq_o : '0);

	modport dev (
		input  k_clk, k_n_clk, load_strobe_n, rw, addr, write_mask_n, dq,
		output dev_dq_o, dev_dq_oe, echo_clock, echo_clock_n, read_valid_flag
	);

	modport ctl (
		output k_clk, k_n_clk, load_strobe_n, rw, addr, write_mask_n, ctl_dq_o, ctl_dq_oe,
		input  dq, echo_clock, echo_clock_n, read_valid_flag
	);

endinterface : dbs_link_if

// ===== rtl/dbs_pkg.sv
package dbs_pkg;

	// ***********************************************
	// Array organisation
	// ***********************************************
	localparam int BURST_LEN   = 2;
	localparam int WORDS_X8    = 2097152;
	localparam int WORDS_X18   = 1048576;
	localparam int WORDS_X36   = 524288;
	localparam int DATA_W_NIB  = 8;
	localparam int LANE_W_NIB  = 4;
	localparam int LANE_W_BYTE = 9;
	localparam int DATA_W_DEF  = 36;

	// ***********************************************
	// Link timing: read latency in link clock cycles, half period in core clock cycles
	// ***********************************************
	localparam int RD_LAT_K    = 2;
	localparam int HALF_DEF    = 2;

	// ***********************************************
	// Direction encoding on the read/write select
	// ***********************************************
	localparam logic RW_READ  = 1'b1;
	localparam logic RW_WRITE = 1'b0;

	// Controller sequencer states
	typedef enum logic [1:0] {
		CS_IDLE,
		CS_CMD,
		CS_WDAT,
		CS_RDWAIT
	} dbs_cst_type;

	// Width of one write-mask lane
	function automatic int lane_w(input int dw);
		return (dw == DATA_W_NIB) ? LANE_W_NIB : LANE_W_BYTE;
	endfunction : lane_w

	// Words held by the part for a data width
	function automatic int depth_words(input int dw);
		if (dw == 36)
			return WORDS_X36;
		else if (dw == 18)
			return WORDS_X18;
		else
			return WORDS_X8;
	endfunction : depth_words

	// Address bits: one address per word pair
	function automatic int pair_addr_w(input int dw);
		return $clog2(depth_words(dw) / BURST_LEN);
	endfunction : pair_addr_w

endpackage : dbs_pkg

// ===== rtl/dbs_sram_ctl.sv
`timescale 1ns/1ps
module dbs_sram_ctl #(
	parameter int DATA_W = dbs_pkg::DATA_W_DEF,
	parameter int HALF   = dbs_pkg::HALF_DEF
) (
	// Clock and reset
	input  wire logic                                 core_clk,
	input  wire logic                                 rst_b,
	// Link to the memory
	dbs_link_if.ctl                                   lnk,
	// Request
	input  wire logic                                 req_valid,
	output logic                                      req_ready,
	input  wire logic                                 req_write,
	input  wire logic [dbs_pkg::pair_addr_w(DATA_W)-1:0] req_addr,
	input  wire logic [DATA_W-1:0]                    req_wdata0,
	input  wire logic [DATA_W-1:0]                    req_wdata1,
	input  wire logic [DATA_W/dbs_pkg::lane_w(DATA_W)-1:0] req_mask0_n,
	input  wire logic [DATA_W/dbs_pkg::lane_w(DATA_W)-1:0] req_mask1_n,
	// Answer
	output logic                                      rsp_valid,
	output logic [DATA_W-1:0]                         rsp_rdata0,
	output logic [DATA_W-1:0]                         rsp_rdata1
);
	import dbs_pkg::*;

	// ***********************************************
	// Clock divider geometry
	// ***********************************************
	localparam int ADDR_W = pair_addr_w(DATA_W);
	localparam int MASK_W = DATA_W / lane_w(DATA_W);
	localparam int CNT_W  = $clog2(2 * HALF);
	localparam logic [CNT_W-1:0] CNT_LAST  = CNT_W'(2 * HALF - 1);
	localparam logic [CNT_W-1:0] PRE_RISE  = CNT_W'(2 * HALF - HALF / 2);
	localparam logic [CNT_W-1:0] PRE_FALL  = CNT_W'(HALF - HALF / 2);
	localparam logic [CNT_W-1:0] SAMP_POS  = CNT_W'(HALF / 2);
	localparam logic [CNT_W-1:0] SAMP_NEG  = CNT_W'(HALF + HALF / 2);

	// Quarter points need an even half period
	if (HALF < 2 || (HALF % 2) != 0) begin : g_bad_half
		$error("dbs_sram_ctl: HALF must be even and at least 2");
	end

	// ***********************************************
	// State
	// ***********************************************
	typedef struct packed {
		logic [CNT_W-1:0]  cnt;
		logic              k;
		dbs_cst_type       st;
		logic              wr;
		logic [DATA_W-1:0] d0;
		logic [DATA_W-1:0] d1;
		logic [MASK_W-1:0] m0_n;
		logic [MASK_W-1:0] m1_n;
		logic              ld_n;
		logic              rw;
		logic [ADDR_W-1:0] addr;
		logic [DATA_W-1:0] dq;
		logic              oe;
		logic [MASK_W-1:0] mask_n;
		logic              got0;
		logic [DATA_W-1:0] rd0;
		logic [DATA_W-1:0] rd1;
		logic              rsp;
	} dbs_creg_type;

	dbs_creg_type     s_r;
	dbs_creg_type     s_nxt;
	logic [CNT_W-1:0] cnt_nxt;
	logic             pre_rise;
	logic             pre_fall;

	// Divider count, apart from the state copy to avoid a loop
	assign cnt_nxt   = (s_r.cnt == CNT_LAST) ? '0 : s_r.cnt + 1'b1;
	// Quarter points where link outputs may change
	assign pre_rise  = (cnt_nxt == PRE_RISE);
	assign pre_fall  = (cnt_nxt == PRE_FALL);
	assign req_ready = (s_r.st == CS_IDLE) && pre_rise;

	// ***********************************************
	// Sequencer
	// ***********************************************
	always_comb begin
		s_nxt     = s_r;
		s_nxt.rsp = 1'b0;
		s_nxt.cnt = cnt_nxt;
		s_nxt.k   = (cnt_nxt < CNT_W'(HALF));
		case (s_r.st)
			CS_IDLE: begin
				// Present command a quarter before the rise
				if (req_valid && pre_rise) begin
					s_nxt.ld_n = 1'b0;
					s_nxt.rw   = req_write ? RW_WRITE : RW_READ;
					s_nxt.addr = req_addr;
					s_nxt.wr   = req_write;
					s_nxt.d0   = req_wdata0;
					s_nxt.d1   = req_wdata1;
					s_nxt.m0_n = req_mask0_n;
					s_nxt.m1_n = req_mask1_n;
					s_nxt.st   = CS_CMD;
				end
			end
			CS_CMD: begin
				// Command taken; drop strobe, send first beat of a write
				if (pre_rise) begin
					s_nxt.ld_n = 1'b1;
					s_nxt.got0 = 1'b0;
					if (s_r.wr) begin
						s_nxt.dq     = s_r.d0;
						s_nxt.mask_n = s_r.m0_n;
						s_nxt.oe     = 1'b1;
						s_nxt.st     = CS_WDAT;
					end else begin
						s_nxt.st = CS_RDWAIT;
					end
				end
			end
			CS_WDAT: begin
				// Second beat for the negative clock rise
				if (pre_fall) begin
					s_nxt.dq     = s_r.d1;
					s_nxt.mask_n = s_r.m1_n;
				end
				// Release the lanes after the burst
				if (pre_rise) begin
					s_nxt.oe     = 1'b0;
					s_nxt.dq     = '0;
					s_nxt.mask_n = '1;
					s_nxt.rsp    = 1'b1;
					s_nxt.st     = CS_IDLE;
				end
			end
			CS_RDWAIT: begin
				// Sample mid-phase while the valid flag is up
				if (lnk.read_valid_flag && s_r.cnt == SAMP_POS) begin
					s_nxt.rd0  = lnk.dq;
					s_nxt.got0 = 1'b1;
				end
				if (lnk.read_valid_flag && s_r.got0 && s_r.cnt == SAMP_NEG) begin
					s_nxt.rd1 = lnk.dq;
					s_nxt.rsp = 1'b1;
					s_nxt.st  = CS_IDLE;
				end
			end
			default: begin
				s_nxt.st = CS_IDLE;
			end
		endcase
	end

	// State register
	always_ff @(posedge core_clk or negedge rst_b) begin
		if (!rst_b) begin
			s_r        <= '0;
			s_r.ld_n   <= 1'b1;
			s_r.mask_n <= '1;
		end else begin
			s_r <= s_nxt;
		end
	end

	// ***********************************************
	// Outputs
	// ***********************************************
	assign lnk.k_clk         = s_r.k;
	assign lnk.k_n_clk       = ~s_r.k;
	assign lnk.load_strobe_n = s_r.ld_n;
	assign lnk.rw            = s_r.rw;
	assign lnk.addr          = s_r.addr;
	assign lnk.write_mask_n  = s_r.mask_n;
	assign lnk.ctl_dq_o      = s_r.dq;
	assign lnk.ctl_dq_oe     = s_r.oe;
	assign rsp_valid         = s_r.rsp;
	assign rsp_rdata0        = s_r.rd0;
	assign rsp_rdata1        = s_r.rd1;

endmodule : dbs_sram_ctl

// ===== rtl/dbs_sram_dev.sv
`timescale 1ns/1ps
module dbs_sram_dev #(
	parameter int DATA_W = dbs_pkg::DATA_W_DEF
) (
	// Link to the controller
	dbs_link_if.dev        lnk,
	// Model reset
	input  wire logic      rst_b,
	// Status
	output logic           access_busy
);
	import dbs_pkg::*;

	// ***********************************************
	// Geometry
	// ***********************************************
	localparam int LANE_W = lane_w(DATA_W);
	localparam int MASK_W = DATA_W / LANE_W;
	localparam int ADDR_W = pair_addr_w(DATA_W);
	localparam int PAIRS  = 2 ** ADDR_W;

	// Refuse widths that have no lane layout
	if (!(DATA_W == 8 || DATA_W == 9 || DATA_W == 18 || DATA_W == 36)) begin : g_bad_width
		$error("dbs_sram_dev: data width must be 8, 9, 18 or 36");
	end
	// The link must be built for the same geometry
	if ($bits(lnk.addr) != ADDR_W || $bits(lnk.write_mask_n) != MASK_W) begin : g_bad_link
		$error("dbs_sram_dev: link geometry does not match");
	end
	// The read pipe needs at least two stages
	if (RD_LAT_K < 2) begin : g_bad_lat
		$error("dbs_sram_dev: read latency too short");
	end

	// ***********************************************
	// State on the positive input clock
	// ***********************************************
	typedef struct packed {
		logic                             wr_load;
		logic [ADDR_W-1:0]                wr_addr;
		logic                             wr_commit;
		logic [ADDR_W-1:0]                cm_addr;
		logic [DATA_W-1:0]                d0;
		logic [MASK_W-1:0]                m0_n;
		logic [RD_LAT_K-1:0]              rd_v;
		logic [RD_LAT_K-1:0][ADDR_W-1:0]  rd_a;
		logic                             drive;
		logic [DATA_W-1:0]                out0;
		logic [DATA_W-1:0]                hold1;
		logic                             ph;
	} dbs_kst_type;

	// ***********************************************
	// State on the negative input clock
	// ***********************************************
	typedef struct packed {
		logic [DATA_W-1:0]                d1;
		logic [MASK_W-1:0]                m1_n;
		logic [DATA_W-1:0]                out1;
		logic                             ph;
	} dbs_nst_type;

	dbs_kst_type         k_r;
	dbs_kst_type         k_nxt;
	dbs_nst_type         n_r;
	dbs_nst_type         n_nxt;
	logic [2*DATA_W-1:0] mem [PAIRS];
	logic [2*DATA_W-1:0] rd_pair;
	logic [2*DATA_W-1:0] wr_pair;
	logic                ld_rd;
	logic                ld_wr;

	// ***********************************************
	// Command decode
	// ***********************************************
	// Nothing is loaded while the strobe is high
	assign ld_rd = !lnk.load_strobe_n && (lnk.rw == RW_READ);
	assign ld_wr = !lnk.load_strobe_n && (lnk.rw == RW_WRITE);

	// Word pair addressed by the launching read
	assign rd_pair = mem[k_r.rd_a[RD_LAT_K-1]];

	// ***********************************************
	// Positive clock next state
	// ***********************************************
	always_comb begin
		k_nxt = k_r;
		// Address and direction taken on this edge only
		k_nxt.wr_load = ld_wr;
		if (ld_wr) begin
			k_nxt.wr_addr = lnk.addr;
		end
		// First write beat and its mask, one cycle on
		k_nxt.wr_commit = k_r.wr_load;
		if (k_r.wr_load) begin
			k_nxt.cm_addr = k_r.wr_addr;
			k_nxt.d0      = lnk.dq;
			k_nxt.m0_n    = lnk.write_mask_n;
		end
		// Read address pipe
		k_nxt.rd_v = {k_r.rd_v[RD_LAT_K-2:0], ld_rd};
		k_nxt.rd_a = {k_r.rd_a[RD_LAT_K-2:0], lnk.addr};
		// Launch a pair when the pipe end is reached
		k_nxt.drive = k_r.rd_v[RD_LAT_K-1];
		if (k_r.rd_v[RD_LAT_K-1]) begin
			k_nxt.out0  = rd_pair[DATA_W-1:0];
			k_nxt.hold1 = rd_pair[2*DATA_W-1:DATA_W];
		end
		// Mark the positive edge as the latest one
		k_nxt.ph = ~n_r.ph;
	end

	// Positive clock register
	always_ff @(posedge lnk.k_clk or negedge rst_b) begin
		if (!rst_b) begin
			k_r <= '0;
		end else begin
			k_r <= k_nxt;
		end
	end

	// ***********************************************
	// Negative clock next state
	// ***********************************************
	always_comb begin
		n_nxt = n_r;
		// Second write beat and its own mask
		n_nxt.d1   = lnk.dq;
		n_nxt.m1_n = lnk.write_mask_n;
		// Second read word follows half a cycle later
		n_nxt.out1 = k_r.hold1;
		// Mark the negative edge as the latest one
		n_nxt.ph   = k_r.ph;
	end

	// Negative clock register
	always_ff @(posedge lnk.k_n_clk or negedge rst_b) begin
		if (!rst_b) begin
			n_r <= '0;
		end else begin
			n_r <= n_nxt;
		end
	end

	// ***********************************************
	// Array write with lane merge
	// ***********************************************
	// Lanes with their mask low take new data, others keep old
	always_comb begin
		wr_pair = mem[k_r.cm_addr];
		for (int i = 0; i < MASK_W; i++) begin
			if (!k_r.m0_n[i]) begin
				wr_pair[i*LANE_W +: LANE_W] = k_r.d0[i*LANE_W +: LANE_W];
			end
			if (!n_r.m1_n[i]) begin
				wr_pair[DATA_W+i*LANE_W +: LANE_W] = n_r.d1[i*LANE_W +: LANE_W];
			end
		end
	end

	// Commit the pair once both beats are in
	always_ff @(posedge lnk.k_clk) begin
		if (k_r.wr_commit) begin
			mem[k_r.cm_addr] <= wr_pair;
		end
	end

	// ***********************************************
	// Link outputs
	// ***********************************************
	// Word of whichever clock rose last
	assign lnk.dev_dq_o        = (k_r.ph != n_r.ph) ? k_r.out0 : n_r.out1;
	// Drivers released outside a read burst
	assign lnk.dev_dq_oe       = k_r.drive;
	// Valid changes only on the positive rise
	assign lnk.read_valid_flag = k_r.drive;
	// Echo clocks are the input clocks, always running
	assign lnk.echo_clock      = lnk.k_clk;
	assign lnk.echo_clock_n    = lnk.k_n_clk;

	// Any access still in flight
	assign access_busy = k_r.wr_load | k_r.wr_commit | (|k_r.rd_v) | k_r.drive;

endmodule : dbs_sram_dev

// ===== sim/dbs_link_monitor.sv
`timescale 1ns/1ps
// ***********************************************
// Link checker, watches the joined interface
// ***********************************************
module dbs_link_monitor #(
	parameter int MASK_W = 4
) (
	// Link clocks and reset
	input wire logic              k_clk,
	input wire logic              k_n_clk,
	input wire logic              rst_b,
	// Command and masks
	input wire logic              load_strobe_n,
	input wire logic              rw,
	input wire logic [MASK_W-1:0] write_mask_n,
	// Data drivers and read return
	input wire logic              ctl_dq_oe,
	input wire logic              dev_dq_oe,
	input wire logic              echo_clock,
	input wire logic              echo_clock_n,
	input wire logic              read_valid_flag
);
	default clocking dc @(posedge k_clk);
	endclocking
	default disable iff (!rst_b);

	// Loaded commands
	sequence rd_load;
		!load_strobe_n && rw;
	endsequence
	sequence wr_load;
		!load_strobe_n && !rw;
	endsequence

	// Valid three cycles after load, one cycle long
	a_valid_latency: assert property (rd_load |-> ##3 read_valid_flag ##1 !read_valid_flag)
		else $error("read valid flag off its slot");
	a_valid_cause: assert property ($rose(read_valid_flag) |-> $past(!load_strobe_n && rw, 3))
		else $error("read valid flag without a loaded read");
	a_write_beats: assert property (wr_load |=> ctl_dq_oe ##1 !ctl_dq_oe)
		else $error("write data not driven for one pair");
	a_read_quiet: assert property (rd_load |-> !ctl_dq_oe [*4])
		else $error("controller drives data during a read");
	a_strobe_pulse: assert property (!load_strobe_n |=> load_strobe_n)
		else $error("load strobe low for more than one cycle");
	a_mask_idle: assert property (!ctl_dq_oe |-> write_mask_n == {MASK_W{1'b1}})
		else $error("write mask active outside write beats");
	a_drive_cause: assert property (dev_dq_oe |-> $past(!load_strobe_n && rw, 3))
		else $error("device drives data without a loaded read");
	a_bus_exclusive: assert property (@(posedge k_n_clk) disable iff (!rst_b)
		!(ctl_dq_oe && dev_dq_oe))
		else $error("both ends drive the data lanes");
	a_echo_follow: assert property (@(posedge k_n_clk) disable iff (!rst_b)
		echo_clock == k_clk && echo_clock_n == k_n_clk)
		else $error("echo clocks do not follow input clocks");

	c_read: cover property (rd_load);
endmodule : dbs_link_monitor

// ===== sim/ddr_burst_sram_port_test.sv
`timescale 1ns/1ps
`define CHK(got, exp) begin checks++; if ((got) !== (exp)) begin fail_count++; \
	$display("unexpected at %0t: got %h expected %h", $time, got, exp); end end
module ddr_burst_sram_port_test;
	import dbs_pkg::*;
	localparam int DW = DATA_W_DEF;
	localparam int AW = pair_addr_w(DW);
	localparam int MW = DW / lane_w(DW);

	// ***********************************************
	// Stimulus and bookkeeping
	// ***********************************************
	logic           core_clk   = 1'b0;
	logic           rst_b      = 1'b0;
	logic           req_valid  = 1'b0;
	logic           req_write  = 1'b0;
	logic [AW-1:0]  req_addr   = '0;
	logic [DW-1:0]  req_wdata0 = '0;
	logic [DW-1:0]  req_wdata1 = '0;
	logic [MW-1:0]  req_mask0_n = '1;
	logic [MW-1:0]  req_mask1_n = '1;
	logic           req_ready;
	logic           rsp_valid;
	logic [DW-1:0]  rsp_rdata0;
	logic [DW-1:0]  rsp_rdata1;
	logic           dev_busy;
	int             fail_count = 0;
	int             checks     = 0;
	integer         seed       = 32'he2fc3760;
	logic [2*DW:0]  notes[$];
	logic [2*DW-1:0] mem [logic [AW-1:0]];
	logic [AW-1:0]  addrs [8];

	// Core clock, 100 MHz
	initial begin
		forever #5 core_clk = ~core_clk;
	end

	// ***********************************************
	// Both ends joined by the link
	// ***********************************************
	dbs_link_if #(.DATA_W(DW)) lnk ();
	dbs_sram_dev #(.DATA_W(DW)) dbs_sram_dev_i (.lnk(lnk), .rst_b(rst_b), .access_busy(dev_busy));
	dbs_sram_ctl #(.DATA_W(DW), .HALF(HALF_DEF)) dbs_sram_ctl_i (
		.core_clk(core_clk), .rst_b(rst_b), .lnk(lnk),
		.req_valid(req_valid), .req_ready(req_ready), .req_write(req_write), .req_addr(req_addr),
		.req_wdata0(req_wdata0), .req_wdata1(req_wdata1), .req_mask0_n(req_mask0_n),
		.req_mask1_n(req_mask1_n), .rsp_valid(rsp_valid), .rsp_rdata0(rsp_rdata0),
		.rsp_rdata1(rsp_rdata1));
	dbs_link_monitor #(.MASK_W(MW)) dbs_link_monitor_i (
		.k_clk(lnk.k_clk), .k_n_clk(lnk.k_n_clk), .rst_b(rst_b), .load_strobe_n(lnk.load_strobe_n),
		.rw(lnk.rw), .write_mask_n(lnk.write_mask_n), .ctl_dq_oe(lnk.ctl_dq_oe),
		.dev_dq_oe(lnk.dev_dq_oe), .echo_clock(lnk.echo_clock), .echo_clock_n(lnk.echo_clock_n),
		.read_valid_flag(lnk.read_valid_flag));

	// Random data word
	function automatic logic [DW-1:0] rnd();
		return DW'({$random(seed), $random(seed)});
	endfunction : rnd

	// Merge one beat under its lane mask
	function automatic logic [DW-1:0] merge(input logic [DW-1:0] old, input logic [DW-1:0] nw,
		input logic [MW-1:0] m_n);
		logic [DW-1:0] r;
		r = old;
		for (int i = 0; i < MW; i++) begin
			if (!m_n[i]) begin
				r[i*LANE_W_BYTE +: LANE_W_BYTE] = nw[i*LANE_W_BYTE +: LANE_W_BYTE];
			end
		end
		return r;
	endfunction : merge

	// One request; valid stays high for a following one
	task automatic do_req(input logic wr, input logic [AW-1:0] a, input logic [DW-1:0] d0,
		input logic [DW-1:0] d1, input logic [MW-1:0] m0, input logic [MW-1:0] m1);
		int n;
		n = 0;
		req_valid   = 1'b1;
		req_write   = wr;
		req_addr    = a;
		req_wdata0  = d0;
		req_wdata1  = d1;
		req_mask0_n = m0;
		req_mask1_n = m1;
		@(negedge core_clk);
		while (req_ready !== 1'b1 && n < 100) begin
			n++;
			@(negedge core_clk);
		end
		`CHK(req_ready, 1'b1)
		@(posedge core_clk);
		#1;
		if (wr) begin
			mem[a] = {merge(mem[a][2*DW-1:DW], d1, m1), merge(mem[a][DW-1:0], d0, m0)};
			notes.push_back({1'b0, {2*DW{1'b0}}});
		end else begin
			notes.push_back({1'b1, mem[a]});
		end
	endtask : do_req

	// Answers against the oldest note, mid-cycle once settled
	always @(negedge core_clk) begin
		logic [2*DW:0] nt;
		if (rsp_valid === 1'b1) begin
			`CHK(notes.size() > 0, 1'b1)
			if (notes.size() > 0) begin
				nt = notes.pop_front();
				if (nt[2*DW]) begin
					`CHK(rsp_rdata0, nt[DW-1:0])
					`CHK(rsp_rdata1, nt[2*DW-1:DW])
				end
			end
		end
	end

	// Counts and verdict
	task automatic close_out();
		$display("checks %0d, mismatches %0d", checks, fail_count);
		if (fail_count == 0 && checks > 0) begin
			$display("Finished cleanly");
		end else begin
			$display("Finished with errors");
		end
		$finish;
	endtask : close_out

	// Watchdog
	initial begin
		#100000;
		fail_count++;
		close_out();
	end

	// ***********************************************
	// Main sequence
	// ***********************************************
	initial begin
		repeat (2) @(posedge core_clk);
		#1;
		rst_b = 1'b1;
		// Full pairs, lowest and highest address among them
		for (int i = 0; i < 8; i++) begin
			addrs[i] = (i == 0) ? '0 : (i == 7) ? '1 : AW'($random(seed));
			do_req(1'b1, addrs[i], rnd(), rnd(), '0, '0);
		end
		for (int i = 0; i < 8; i++) begin
			do_req(1'b0, addrs[i], rnd(), rnd(), '1, '1);
		end
		// Every lane mask, different per beat, read back at once
		for (int m = 0; m < 16; m++) begin
			do_req(1'b1, addrs[m % 8], rnd(), rnd(), MW'(m), ~MW'(m));
			do_req(1'b0, addrs[m % 8], rnd(), rnd(), '1, '1);
		end
		req_valid = 1'b0;
		repeat (40) @(posedge core_clk);
		#1;
		`CHK(notes.size(), 0)
		`CHK({lnk.ctl_dq_oe, lnk.dev_dq_oe}, 2'b00)
		`CHK(dev_busy, 1'b0)
		close_out();
	end
endmodule : ddr_burst_sram_port_test
